//--- rtl/scmc_pkg.sv
// constants, types and field layout of the system clock and mode controller
package scmc_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_CLK_MODE = 8'h00;
	localparam logic [7:0] ADDR_FAST_RC = 8'h04;
	localparam logic [7:0] ADDR_XTAL = 8'h08;
	localparam logic [7:0] ADDR_INT_STAT = 8'h0c;
	localparam logic [7:0] ADDR_INT_MASK = 8'h10;
	// clock mode register fields
	localparam int SEL_MSB = 7;
	localparam int SEL_LSB = 5;
	localparam int KEEP_FAST_BIT = 1;
	localparam int KEEP_SLOW_BIT = 0;
	// fast rc and crystal register fields
	localparam int FREQ_MSB = 3;
	localparam int FREQ_LSB = 2;
	localparam int STABLE_BIT = 1;
	localparam int ON_BIT = 0;
	// reset values and the slow select code
	localparam logic [2:0] SEL_RST = 3'h1;
	localparam logic KEEP_RST = 1'b0;
	localparam logic [1:0] FREQ_RST = 2'h0;
	localparam logic FAST_ON_RST = 1'b1;
	localparam logic [2:0] SEL_SLOW = 3'h7;
	// interrupt status bits
	localparam int INT_W = 4;
	localparam int INT_FAST_STABLE = 0;
	localparam int INT_XTAL_STABLE = 1;
	localparam int INT_SWITCH_DONE = 2;
	localparam int INT_HALT = 3;
	// settle times and derived cycle counts at the system clock rate
	localparam int SYS_CLK_NS = 10;
	localparam int FAST_SETTLE_NS = 20000;
	localparam int FAST_SETTLE_CYC = (FAST_SETTLE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int XTAL_SETTLE_NS = 2000000;
	localparam int XTAL_SETTLE_CYC = (XTAL_SETTLE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	// operating modes
	typedef enum logic [5:0] {
		MODE_FAST = 6'h01,
		MODE_SLOW = 6'h02,
		MODE_SLEEP = 6'h04,
		MODE_STANDBY_SLOW_ONLY = 6'h08,
		MODE_STANDBY_BOTH_CLOCKS = 6'h10,
		MODE_STANDBY_FAST_ONLY = 6'h20
	} scmc_mode_type;
	// clock and power controls driven to the chip
	typedef struct packed {
		logic cpu_run;
		logic fast_osc_en;
		logic fast_periph_en;
		logic slow_periph_en;
		logic sysclk_run;
	} scmc_clk_ctl_type;
endpackage

//--- rtl/scmc_top.sv
// system clock selection, operating mode control and oscillator status
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module scmc_top import scmc_pkg::*; #(
	parameter int XTAL_SETTLE = XTAL_SETTLE_CYC
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fast_osc_clk,
	input wire logic slow_osc_clk,
	input wire logic halt_req,
	input wire logic wake_req,
	output logic sysclk_out,
	output scmc_clk_ctl_type clk_ctl,
	output logic [1:0] fast_rc_freq,
	output scmc_mode_type op_mode,
	output logic irq
);
	logic [2:0] sel, cur_sel;
	logic keep_fast, keep_slow;
	logic [1:0] freq_sel;
	logic fast_on, fast_stable, xtal_stable;
	logic [11:0] fast_cnt;
	logic [19:0] xtal_cnt;
	logic fast_q, slow_q;
	logic [5:0] div_cnt;
	logic sys_gate, rd_hit;
	logic [INT_W-1:0] int_stat, int_mask, int_ev;
	logic [31:0] rd_val;
	logic next_fast_en, next_sys_run, next_slow_periph;
	logic acc, wr, freq_chg, fast_restart, fast_done, xtal_done;
	logic sel_ok, sw_go, halt_ev, cur_slow;

	// clock level of a select code: direct, divided or slow
	function automatic logic src_level(input logic [2:0] code,
		input logic f, input logic [5:0] d, input logic s);
		case (code)
			3'h0: src_level = f;
			3'h1: src_level = d[0];
			3'h2: src_level = d[1];
			3'h3: src_level = d[2];
			3'h4: src_level = d[3];
			3'h5: src_level = d[4];
			3'h6: src_level = d[5];
			default: src_level = s;
		endcase
	endfunction

	function automatic logic is_run(input scmc_mode_type m);
		is_run = (m == MODE_FAST) || (m == MODE_SLOW);
	endfunction

	// bus access decode
	assign acc = psel & penable & ~pready;
	assign wr = acc & pwrite;
	assign freq_chg = wr & (paddr == ADDR_FAST_RC) &
		(pwdata[FREQ_MSB:FREQ_LSB] != freq_sel);
	assign cur_slow = (cur_sel == SEL_SLOW);
	assign halt_ev = halt_req & is_run(op_mode);

	// register read mux, unused bits read zero
	always_comb begin
		rd_val = 32'h0;
		rd_hit = 1'b1;
		case (paddr)
			ADDR_CLK_MODE: begin
				rd_val[SEL_MSB:SEL_LSB] = sel;
				rd_val[KEEP_FAST_BIT] = keep_fast;
				rd_val[KEEP_SLOW_BIT] = keep_slow;
			end
			ADDR_FAST_RC: begin
				rd_val[FREQ_MSB:FREQ_LSB] = freq_sel;
				rd_val[STABLE_BIT] = fast_stable;
				rd_val[ON_BIT] = fast_on;
			end
			ADDR_XTAL: begin
				rd_val[STABLE_BIT] = xtal_stable;
				rd_val[ON_BIT] = 1'b1;
			end
			ADDR_INT_STAT: rd_val[INT_W-1:0] = int_stat;
			ADDR_INT_MASK: rd_val[INT_W-1:0] = int_mask;
			default: rd_hit = 1'b0;
		endcase
	end

	// apb answer one cycle into the access phase
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= acc;
			pslverr <= acc & ~rd_hit;
			prdata <= (acc & ~pwrite) ? rd_val : 32'h0;
		end
	end

	// software writable control bits; stable flags have no write path
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sel <= SEL_RST;
			keep_fast <= KEEP_RST;
			keep_slow <= KEEP_RST;
			freq_sel <= FREQ_RST;
			fast_on <= FAST_ON_RST;
			int_mask <= '0;
		end else if (wr) begin
			case (paddr)
				ADDR_CLK_MODE: begin
					sel <= pwdata[SEL_MSB:SEL_LSB];
					keep_fast <= pwdata[KEEP_FAST_BIT];
					keep_slow <= pwdata[KEEP_SLOW_BIT];
				end
				ADDR_FAST_RC: begin
					freq_sel <= pwdata[FREQ_MSB:FREQ_LSB];
					fast_on <= pwdata[ON_BIT];
				end
				ADDR_INT_MASK: int_mask <= pwdata[INT_W-1:0];
				default: ;
			endcase
		end
	end

	// oscillator and clock requests per mode
	always_comb begin
		next_fast_en = 1'b0;
		next_sys_run = 1'b0;
		next_slow_periph = 1'b0;
		case (op_mode)
			MODE_FAST, MODE_SLOW: begin
				// fast osc may stop only while running slow
				next_fast_en = fast_on | ~cur_slow | (sel != SEL_SLOW);
				next_sys_run = 1'b1;
				next_slow_periph = 1'b1;
			end
			MODE_SLEEP: ;
			MODE_STANDBY_SLOW_ONLY: begin
				next_sys_run = cur_slow;
				next_slow_periph = 1'b1;
			end
			MODE_STANDBY_BOTH_CLOCKS: begin
				next_fast_en = 1'b1;
				next_sys_run = 1'b1;
				next_slow_periph = 1'b1;
			end
			MODE_STANDBY_FAST_ONLY: begin
				next_fast_en = 1'b1;
				next_sys_run = ~cur_slow;
			end
			default: ;
		endcase
	end

	// registered clock controls
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			clk_ctl <= '0;
		end else begin
			clk_ctl.cpu_run <= is_run(op_mode);
			clk_ctl.fast_osc_en <= next_fast_en;
			clk_ctl.fast_periph_en <= next_fast_en & fast_stable;
			clk_ctl.slow_periph_en <= next_slow_periph;
			clk_ctl.sysclk_run <= sys_gate;
		end
	end

	// fast oscillator settle counter and stable flag
	assign fast_restart = (next_fast_en & ~clk_ctl.fast_osc_en) | freq_chg;
	assign fast_done = next_fast_en & ~fast_restart & ~fast_stable &
		(fast_cnt == 12'(FAST_SETTLE_CYC - 1));
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fast_cnt <= '0;
			fast_stable <= 1'b0;
		end else if (!next_fast_en || fast_restart) begin
			fast_cnt <= '0;
			fast_stable <= 1'b0;
		end else if (fast_done) begin
			fast_stable <= 1'b1;
		end else if (!fast_stable) begin
			fast_cnt <= fast_cnt + 12'h1;
		end
	end

	// new frequency code is applied once the oscillator settles
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fast_rc_freq <= FREQ_RST;
		end else if (fast_done) begin
			fast_rc_freq <= freq_sel;
		end
	end

	// crystal is always on; flag rises once after settling
	assign xtal_done = ~xtal_stable & (xtal_cnt == 20'(XTAL_SETTLE - 1));
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			xtal_cnt <= '0;
			xtal_stable <= 1'b0;
		end else if (xtal_done) begin
			xtal_stable <= 1'b1;
		end else if (!xtal_stable) begin
			xtal_cnt <= xtal_cnt + 20'h1;
		end
	end

	// sampled oscillator levels and binary divider of the fast clock
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fast_q <= 1'b0;
			slow_q <= 1'b0;
			div_cnt <= '0;
		end else begin
			fast_q <= fast_osc_clk & next_fast_en;
			slow_q <= slow_osc_clk;
			if (fast_osc_clk & ~fast_q & next_fast_en) begin
				div_cnt <= div_cnt + 6'h1;
			end
		end
	end

	// source change only with target stable and both clocks low
	assign sel_ok = (sel == SEL_SLOW) ? xtal_stable : fast_stable;
	assign sw_go = (sel != cur_sel) & sel_ok &
		~src_level(cur_sel, fast_q, div_cnt, slow_q) &
		~src_level(sel, fast_q, div_cnt, slow_q);
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cur_sel <= SEL_RST;
		end else if (sw_go) begin
			cur_sel <= sel;
		end
	end

	// glitch-free gate and system clock output
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sys_gate <= 1'b1;
			sysclk_out <= 1'b0;
		end else begin
			if (!src_level(cur_sel, fast_q, div_cnt, slow_q)) begin
				sys_gate <= next_sys_run;
			end
			sysclk_out <= sys_gate &
				src_level(cur_sel, fast_q, div_cnt, slow_q);
		end
	end

	// operating mode state machine
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			op_mode <= MODE_FAST;
		end else begin
			case (op_mode)
				MODE_FAST, MODE_SLOW: begin
					if (halt_req) begin
						case ({keep_fast, keep_slow})
							2'b00: op_mode <= MODE_SLEEP;
							2'b01: op_mode <= MODE_STANDBY_SLOW_ONLY;
							2'b11: op_mode <= MODE_STANDBY_BOTH_CLOCKS;
							default: op_mode <= MODE_STANDBY_FAST_ONLY;
						endcase
					end else begin
						op_mode <= cur_slow ? MODE_SLOW : MODE_FAST;
					end
				end
				MODE_SLEEP, MODE_STANDBY_SLOW_ONLY,
				MODE_STANDBY_BOTH_CLOCKS, MODE_STANDBY_FAST_ONLY: begin
					if (wake_req) begin
						op_mode <= cur_slow ? MODE_SLOW : MODE_FAST;
					end
				end
				default: op_mode <= MODE_FAST;
			endcase
		end
	end

	// sticky event flags, write one to clear, set wins
	always_comb begin
		int_ev = '0;
		int_ev[INT_FAST_STABLE] = fast_done;
		int_ev[INT_XTAL_STABLE] = xtal_done;
		int_ev[INT_SWITCH_DONE] = sw_go;
		int_ev[INT_HALT] = halt_ev;
	end
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			int_stat <= '0;
			irq <= 1'b0;
		end else begin
			if (wr && paddr == ADDR_INT_STAT) begin
				int_stat <= (int_stat & ~pwdata[INT_W-1:0]) | int_ev;
			end else begin
				int_stat <= int_stat | int_ev;
			end
			irq <= |(int_stat & int_mask);
		end
	end

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	sequence seq_freq_write;
		freq_chg && clk_ctl.fast_osc_en;
	endsequence

	chk_slow_source: assert property (
		(sys_gate && cur_sel == SEL_SLOW) |=> sysclk_out == $past(slow_q))
		else $error("slow select does not follow slow clock");
	chk_div_two: assert property (
		(sys_gate && cur_sel == 3'h1) |=> sysclk_out == $past(div_cnt[0]))
		else $error("divide by two source wrong");
	chk_halt_leaves_run: assert property (
		(halt_req && is_run(op_mode)) |=> !is_run(op_mode))
		else $error("halt did not leave running mode");
	chk_sleep_clocks: assert property (
		op_mode == MODE_SLEEP |=> !clk_ctl.cpu_run && !clk_ctl.fast_osc_en
		&& !clk_ctl.slow_periph_en)
		else $error("sleep left a clock running");
	chk_stby_slow_clocks: assert property (
		op_mode == MODE_STANDBY_SLOW_ONLY |=> !clk_ctl.fast_osc_en
		&& clk_ctl.slow_periph_en && !clk_ctl.cpu_run)
		else $error("slow standby clocks wrong");
	chk_stby_both_clocks: assert property (
		op_mode == MODE_STANDBY_BOTH_CLOCKS |=> clk_ctl.fast_osc_en
		&& clk_ctl.slow_periph_en && !clk_ctl.cpu_run)
		else $error("both clock standby clocks wrong");
	chk_stby_fast_clocks: assert property (
		op_mode == MODE_STANDBY_FAST_ONLY |=> clk_ctl.fast_osc_en
		&& !clk_ctl.slow_periph_en)
		else $error("fast standby clocks wrong");
	chk_xtal_read_one: assert property (
		(acc && !pwrite && paddr == ADDR_XTAL) |=>
		pready && prdata[ON_BIT] && prdata[31:2] == 30'h0)
		else $error("crystal register read wrong");
	chk_slow_fast_osc: assert property (
		(op_mode == MODE_SLOW && cur_slow && sel == SEL_SLOW) |=>
		clk_ctl.fast_osc_en == $past(fast_on))
		else $error("fast osc ignores enable in slow mode");
	chk_slow_needs_xtal: assert property (
		(cur_sel == SEL_SLOW && $past(cur_sel) != SEL_SLOW)
		|-> $past(xtal_stable))
		else $error("switched to slow before crystal stable");
	chk_fast_needs_flag: assert property (
		(cur_sel != SEL_SLOW && $past(cur_sel) == SEL_SLOW)
		|-> $past(fast_stable))
		else $error("switched to fast before fast osc stable");
	chk_freq_clears_flag: assert property (
		seq_freq_write |=> !fast_stable [*8])
		else $error("frequency change did not clear stable flag");
	chk_freq_applied: assert property (
		$changed(fast_rc_freq) |-> $rose(fast_stable))
		else $error("frequency applied before stable");
	chk_switch_low: assert property (
		$changed(cur_sel) |-> !sysclk_out)
		else $error("clock source switched while high");
endmodule

//--- tb/scmc_core_model.sv
// core side model: oscillator sources, halt and wake operations
`timescale 1ns/10ps
module scmc_core_model #(
	parameter int FAST_HALF = 2,
	parameter int SLOW_HALF = 10
) (
	input wire logic sys_clk,
	input wire logic fast_osc_en,
	output logic fast_osc_clk,
	output logic slow_osc_clk,
	output logic halt_req,
	output logic wake_req
);
	int fcnt = 0;
	int scnt = 0;
	initial begin
		fast_osc_clk = 1'b0;
		slow_osc_clk = 1'b0;
		halt_req = 1'b0;
		wake_req = 1'b0;
	end
	// fast rc level, held low while stopped
	always @(posedge sys_clk) begin
		if (!fast_osc_en) begin
			fcnt <= 0;
			fast_osc_clk <= 1'b0;
		end else if (fcnt == FAST_HALF - 1) begin
			fcnt <= 0;
			fast_osc_clk <= ~fast_osc_clk;
		end else begin
			fcnt <= fcnt + 1;
		end
	end
	// crystal level, never stopped
	always @(posedge sys_clk) begin
		if (scnt == SLOW_HALF - 1) begin
			scnt <= 0;
			slow_osc_clk <= ~slow_osc_clk;
		end else begin
			scnt <= scnt + 1;
		end
	end
	// one-cycle halt pulse from the core
	task automatic halt_op();
		@(posedge sys_clk);
		halt_req <= 1'b1;
		@(posedge sys_clk);
		halt_req <= 1'b0;
	endtask
	// one-cycle wake pulse
	task automatic wake_op();
		@(posedge sys_clk);
		wake_req <= 1'b1;
		@(posedge sys_clk);
		wake_req <= 1'b0;
	endtask
endmodule

//--- tb/system_clock_mode_control_test.sv
// self-checking bench for the system clock and mode controller
`timescale 1ns/10ps
module system_clock_mode_control_test;
	import scmc_pkg::*;
	localparam int FP = 4;
	localparam int SP = 20;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, fast_osc_clk, slow_osc_clk, halt_req, wake_req;
	logic sysclk_out, irq;
	scmc_clk_ctl_type clk_ctl;
	logic [1:0] fast_rc_freq;
	scmc_mode_type op_mode;
	int err_total = 0;
	int checks_done = 0;
	// 100 MHz system clock
	always #5 sys_clk = ~sys_clk;
	scmc_top #(.XTAL_SETTLE(20)) DUT (.sys_clk(sys_clk), .arst_n(arst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fast_osc_clk(fast_osc_clk),
		.slow_osc_clk(slow_osc_clk), .halt_req(halt_req),
		.wake_req(wake_req), .sysclk_out(sysclk_out), .clk_ctl(clk_ctl),
		.fast_rc_freq(fast_rc_freq), .op_mode(op_mode), .irq(irq));
	scmc_core_model #(.FAST_HALF(FP / 2), .SLOW_HALF(SP / 2)) core (
		.sys_clk(sys_clk), .fast_osc_en(clk_ctl.fast_osc_en),
		.fast_osc_clk(fast_osc_clk), .slow_osc_clk(slow_osc_clk),
		.halt_req(halt_req), .wake_req(wake_req));
	task automatic check(input string w, input logic [31:0] s,
		input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", w, e, s);
		end
	endtask
	// apb transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge sys_clk);
		end
		if (n >= 20) begin
			err_total++;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd_chk(input string w, input logic [7:0] a,
		input logic [31:0] m, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		check(w, r & m, x);
	endtask
	// poll a register bit until set, bounded
	task automatic wait_set(input string w, input logic [7:0] a, input int b);
		logic [31:0] r;
		logic e;
		int n;
		n = 0;
		apb(1'b0, a, 32'h0, r, e);
		while (r[b] !== 1'b1 && n < 3000) begin
			n++;
			apb(1'b0, a, 32'h0, r, e);
		end
		check(w, {31'h0, r[b]}, 32'h1);
	endtask
	// measure one high phase and period of the system clock
	task automatic shape(output int hi, output int per);
		int n;
		n = 0;
		hi = 0;
		per = 0;
		@(posedge sys_clk);
		while (sysclk_out !== 1'b0 && n < 600) begin
			n++;
			@(posedge sys_clk);
		end
		while (sysclk_out !== 1'b1 && n < 600) begin
			n++;
			@(posedge sys_clk);
		end
		while (sysclk_out === 1'b1 && per < 600) begin
			hi++;
			per++;
			@(posedge sys_clk);
		end
		while (sysclk_out === 1'b0 && per < 600) begin
			per++;
			@(posedge sys_clk);
		end
	endtask
	task automatic t_reset_regs();
		logic [31:0] r;
		logic e;
		rd_chk("crystal reg", ADDR_XTAL, 32'hff, 32'h01);
		rd_chk("mode reg", ADDR_CLK_MODE, 32'hff, 32'h20);
		rd_chk("fast rc reg", ADDR_FAST_RC, 32'hff, 32'h01);
		check("mode", {26'h0, op_mode}, MODE_FAST);
		apb(1'b0, 8'h14, 32'h0, r, e);
		check("unmapped data", r, 32'h0);
		check("unmapped err", {31'h0, e}, 32'h1);
		wait_set("crystal stable", ADDR_XTAL, STABLE_BIT);
	endtask
	task automatic t_reserved();
		wr(ADDR_CLK_MODE, 32'hffffff3c);
		rd_chk("mode reserved", ADDR_CLK_MODE, 32'hff, 32'h20);
		wr(ADDR_XTAL, 32'h0);
		rd_chk("crystal ro", ADDR_XTAL, 32'hff, 32'h03);
		wr(ADDR_FAST_RC, 32'hfffffff3);
		rd_chk("fast reserved", ADDR_FAST_RC, 32'hf3, 32'h01);
	endtask
	task automatic t_irq();
		wait_set("fast stable", ADDR_FAST_RC, STABLE_BIT);
		rd_chk("status", ADDR_INT_STAT, 32'h3, 32'h3);
		check("irq masked", {31'h0, irq}, 32'h0);
		wr(ADDR_INT_MASK, 32'h1);
		repeat (2) @(posedge sys_clk);
		check("irq raised", {31'h0, irq}, 32'h1);
		wr(ADDR_INT_STAT, 32'h1);
		repeat (2) @(posedge sys_clk);
		check("irq cleared", {31'h0, irq}, 32'h0);
		rd_chk("status w1c", ADDR_INT_STAT, 32'h3, 32'h2);
		wr(ADDR_INT_MASK, 32'h0);
	endtask
	task automatic t_ratios();
		int hi, per;
		for (int c = 0; c < 8; c++) begin
			wr(ADDR_INT_STAT, 32'hf);
			wr(ADDR_CLK_MODE, {24'h0, c[2:0], 5'h0});
			wait_set("switch", ADDR_INT_STAT, INT_SWITCH_DONE);
			shape(hi, per);
			check("period", per, c == 7 ? SP : FP << c);
			check("high phase", hi, c == 7 ? SP / 2 : (FP / 2) << c);
		end
		check("slow mode", {26'h0, op_mode}, MODE_SLOW);
	endtask
	task automatic t_osc();
		logic [1:0] q[4];
		q = '{2'h1, 2'h2, 2'h3, 2'h0};
		wr(ADDR_FAST_RC, 32'h0);
		repeat (4) @(posedge sys_clk);
		check("fast off", {31'h0, clk_ctl.fast_osc_en}, 32'h0);
		foreach (q[i]) begin
			wr(ADDR_FAST_RC, {28'h0, q[i], 2'h1});
			rd_chk("flag clear", ADDR_FAST_RC, 32'hf, {q[i], 2'h1});
			check("freq held", {30'h0, fast_rc_freq}, i == 0 ? 0 : q[i - 1]);
			wait_set("fast settle", ADDR_FAST_RC, STABLE_BIT);
			check("freq applied", {30'h0, fast_rc_freq}, q[i]);
		end
		check("fast on", {31'h0, clk_ctl.fast_osc_en}, 32'h1);
	endtask
	task automatic t_halt();
		logic kf, ks, sl, run;
		logic [4:0] x;
		scmc_mode_type m;
		for (int i = 0; i < 8; i++) begin
			sl = !i[2];
			kf = i[1];
			ks = i[0];
			if (i == 4) begin
				wr(ADDR_INT_STAT, 32'hf);
				wr(ADDR_CLK_MODE, 32'h0);
				wait_set("to fast", ADDR_INT_STAT, INT_SWITCH_DONE);
			end
			wr(ADDR_CLK_MODE, {24'h0, sl ? 3'h7 : 3'h0, 3'h0, kf, ks});
			wr(ADDR_INT_STAT, 32'h8);
			// fast peripheral clock only shows once the oscillator settled
			if (kf) begin
				wait_set("fast ready", ADDR_FAST_RC, STABLE_BIT);
			end
			core.halt_op();
			repeat (40) @(posedge sys_clk);
			m = !kf ? (ks ? MODE_STANDBY_SLOW_ONLY : MODE_SLEEP) :
				(ks ? MODE_STANDBY_BOTH_CLOCKS : MODE_STANDBY_FAST_ONLY);
			run = (kf & ks) | (ks & !kf & sl) | (kf & !ks & !sl);
			check("halt mode", {26'h0, op_mode}, m);
			x = {1'b0, kf, kf, ks, run};
			check("halt clocks", {27'h0, clk_ctl}, x);
			rd_chk("halt flag", ADDR_INT_STAT, 32'h8, 32'h8);
			core.halt_op();
			repeat (3) @(posedge sys_clk);
			check("halt ignored", {26'h0, op_mode}, m);
			core.wake_op();
			repeat (4) @(posedge sys_clk);
			check("woken", {26'h0, op_mode}, sl ? MODE_SLOW : MODE_FAST);
		end
	endtask
	task automatic print_verdict();
		if (err_total == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// watchdog against a hang
	initial begin
		#1000000;
		err_total++;
		print_verdict();
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		arst_n <= 1'b1;
		t_reset_regs();
		t_reserved();
		t_irq();
		t_ratios();
		t_osc();
		t_halt();
		print_verdict();
	end
endmodule
